// ==== logic/sbbd_top.sv ====
// module: decode and execute of arithmetic shift, conditional branch and bit invert
`timescale 1ns/100ps
module sbbd_top (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic INSTR_VALID_I,
  input wire logic [15:0] INSTR_WORD_I,
  input wire logic [31:0] INSTR_PC_I,
  input wire logic EXT_VALID_I,
  input wire logic [15:0] EXT_WORD_I,
  input wire logic [31:0] DREG_FILE_I,
  input wire logic [31:0] MEM_RDATA_I,
  input wire logic MEM_RVALID_I,
  input wire logic MEM_WDONE_I,
  input wire sbbd_pkg::sbbd_flags_t FLAGS_I,
  output logic BUSY_O,
  output logic DONE_O,
  output logic ILLEGAL_O,
  output logic EXT_REQ_O,
  output logic [2:0] DREG_RSEL_O,
  output logic DREG_WE_O,
  output logic [2:0] DREG_WSEL_O,
  output logic [31:0] DREG_WDATA_O,
  output logic MEM_RREQ_O,
  output logic MEM_WREQ_O,
  output logic [5:0] MEM_EA_O,
  output logic MEM_BYTE_O,
  output logic [31:0] MEM_WDATA_O,
  output logic FLAGS_WE_O,
  output sbbd_pkg::sbbd_flags_t FLAGS_O,
  output logic PC_WE_O,
  output logic [31:0] PC_O
);
  // ****************************************************************
  // state and working registers
  // ****************************************************************
  typedef enum logic [3:0] {
    S_IDLE, S_RD_COUNT, S_RD_OPND, S_MEM_RD, S_MEM_WR, S_EXT_HI, S_EXT_LO,
    S_BIT_NUM, S_FINISH
  } sbbd_state_t;
  typedef enum logic [1:0] {K_SHIFT, K_MSHIFT, K_BRANCH, K_BIT} sbbd_kind_t;

  sbbd_state_t state_r;
  sbbd_kind_t kind_r;
  logic [15:0] op_r;
  logic [31:0] pc_r;
  logic [6:0] count_r;
  logic [31:0] opnd_r;
  logic [31:0] disp_r;
  logic [4:0] bitno_r;
  logic [31:0] res_r;
  sbbd_pkg::sbbd_flags_t flg_r;
  logic need_lo_r;

  sbbd_alu_if alu_bus();
  logic cond_true;
  sbbd_shift u_shift (.alu(alu_bus));
  sbbd_cond u_cond (.cond_i(op_r[11:8]), .flags_i(FLAGS_I), .true_o(cond_true));

  // ****************************************************************
  // decode of a fresh instruction word
  // ****************************************************************
  function automatic logic mem_alterable(input logic [5:0] ea);
    logic [2:0] m;
    logic [2:0] r;
    m = ea[5:3];
    r = ea[2:0];
    mem_alterable = (m >= sbbd_pkg::MODE_IND_FIRST && m <= sbbd_pkg::MODE_IND_LAST) ||
                    (m == sbbd_pkg::MODE_EXT &&
                     (r == sbbd_pkg::EXT_ABS_W || r == sbbd_pkg::EXT_ABS_L));
  endfunction : mem_alterable

  logic w_shift;
  logic w_mshift;
  logic w_branch;
  logic w_bitdyn;
  logic w_bitsta;
  logic w_bit_ea_ok;
  always_comb begin
    w_shift = INSTR_WORD_I[15:12] == sbbd_pkg::OP_SHIFT &&
              INSTR_WORD_I[7:6] != sbbd_pkg::SIZE_MEM &&
              INSTR_WORD_I[4:3] == sbbd_pkg::SHIFT_KIND_ARITH;
    w_mshift = INSTR_WORD_I[15:12] == sbbd_pkg::OP_SHIFT &&
               INSTR_WORD_I[11:9] == 3'h0 &&
               INSTR_WORD_I[7:6] == sbbd_pkg::SIZE_MEM &&
               mem_alterable(INSTR_WORD_I[5:0]);
    w_branch = INSTR_WORD_I[15:12] == sbbd_pkg::OP_BRANCH;
    w_bit_ea_ok = INSTR_WORD_I[5:3] == sbbd_pkg::MODE_DREG ||
                  mem_alterable(INSTR_WORD_I[5:0]);
    w_bitdyn = INSTR_WORD_I[15:12] == sbbd_pkg::OP_BITOP &&
               INSTR_WORD_I[8:6] == sbbd_pkg::BITOP_INVERT && w_bit_ea_ok;
    w_bitsta = INSTR_WORD_I[15:8] == sbbd_pkg::STATIC_BITOP_HI &&
               INSTR_WORD_I[7:6] == sbbd_pkg::STATIC_INVERT_TYPE && w_bit_ea_ok;
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_r <= S_IDLE;
      kind_r <= K_SHIFT;
      op_r <= 16'h0000;
      pc_r <= 32'h0000_0000;
      count_r <= 7'h00;
      opnd_r <= 32'h0000_0000;
      disp_r <= 32'h0000_0000;
      bitno_r <= 5'h00;
      need_lo_r <= 1'b0;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (INSTR_VALID_I) begin
            op_r <= INSTR_WORD_I;
            pc_r <= INSTR_PC_I;
            if (w_shift) begin
              kind_r <= K_SHIFT;
              count_r <= (INSTR_WORD_I[11:9] == 3'h0) ?
                         7'(sbbd_pkg::COUNT_ZERO_MEANS) : {4'h0, INSTR_WORD_I[11:9]};
              state_r <= INSTR_WORD_I[5] ? S_RD_COUNT : S_RD_OPND;
            end else if (w_mshift) begin
              kind_r <= K_MSHIFT;
              count_r <= 7'h01;
              state_r <= S_MEM_RD;
            end else if (w_branch) begin
              kind_r <= K_BRANCH;
              disp_r <= {{24{INSTR_WORD_I[7]}}, INSTR_WORD_I[7:0]};
              if (INSTR_WORD_I[7:0] == sbbd_pkg::DISP_WORD) begin
                need_lo_r <= 1'b0;
                state_r <= S_EXT_LO;
              end else if (INSTR_WORD_I[7:0] == sbbd_pkg::DISP_LONG) begin
                need_lo_r <= 1'b1;
                state_r <= S_EXT_HI;
              end else begin
                state_r <= S_FINISH;
              end
            end else if (w_bitdyn || w_bitsta) begin
              kind_r <= K_BIT;
              state_r <= w_bitsta ? S_BIT_NUM : S_RD_COUNT;
            end else begin
              kind_r <= K_MSHIFT; // refused: this kind writes nothing at finish
              state_r <= S_FINISH;
            end
          end
        end
        S_RD_COUNT: begin
          if (kind_r == K_BIT) begin
            bitno_r <= DREG_FILE_I[4:0];
            state_r <= (op_r[5:3] == sbbd_pkg::MODE_DREG) ? S_RD_OPND : S_MEM_RD;
          end else begin
            count_r <= {1'b0, DREG_FILE_I[5:0] & sbbd_pkg::COUNT_MOD_MASK};
            state_r <= S_RD_OPND;
          end
        end
        S_BIT_NUM: begin
          if (EXT_VALID_I) begin
            bitno_r <= EXT_WORD_I[4:0];
            state_r <= (op_r[5:3] == sbbd_pkg::MODE_DREG) ? S_RD_OPND : S_MEM_RD;
          end
        end
        S_RD_OPND: begin
          opnd_r <= DREG_FILE_I;
          state_r <= S_FINISH;
        end
        S_MEM_RD: begin
          if (MEM_RVALID_I) begin
            opnd_r <= MEM_RDATA_I;
            state_r <= S_MEM_WR;
          end
        end
        S_MEM_WR: begin
          if (MEM_WDONE_I) state_r <= S_IDLE;
        end
        S_EXT_HI: begin
          if (EXT_VALID_I) begin
            disp_r[31:16] <= EXT_WORD_I;
            state_r <= S_EXT_LO;
          end
        end
        S_EXT_LO: begin
          if (EXT_VALID_I) begin
            disp_r <= need_lo_r ? {disp_r[31:16], EXT_WORD_I} :
                      {{16{EXT_WORD_I[15]}}, EXT_WORD_I};
            state_r <= S_FINISH;
          end
        end
        S_FINISH: state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // datapath: shifter feed and bit invert
  // ****************************************************************
  logic is_mem;
  logic [4:0] bit_sel;
  logic tested;
  logic [31:0] inv_val;
  assign is_mem = kind_r == K_MSHIFT || (kind_r == K_BIT && op_r[5:3] != sbbd_pkg::MODE_DREG);
  assign bit_sel = is_mem ? {2'h0, bitno_r[2:0]} : bitno_r;
  assign tested = opnd_r[bit_sel];
  assign inv_val = opnd_r ^ (32'h0000_0001 << bit_sel);

  always_comb begin
    alu_bus.operand = opnd_r;
    alu_bus.count = count_r;
    alu_bus.size = (kind_r == K_MSHIFT) ? sbbd_pkg::SIZE_WORD : op_r[7:6];
    alu_bus.left = op_r[8];
    alu_bus.flags_in = FLAGS_I;
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  logic fin;
  logic mem_end;
  assign fin = state_r == S_FINISH;
  assign mem_end = state_r == S_MEM_WR && MEM_WDONE_I;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      DONE_O <= 1'b0;
      ILLEGAL_O <= 1'b0;
      DREG_WE_O <= 1'b0;
      DREG_WSEL_O <= 3'h0;
      DREG_WDATA_O <= 32'h0000_0000;
      FLAGS_WE_O <= 1'b0;
      FLAGS_O <= '0;
      PC_WE_O <= 1'b0;
      PC_O <= 32'h0000_0000;
      MEM_WDATA_O <= 32'h0000_0000;
    end else begin
      DONE_O <= fin || mem_end;
      ILLEGAL_O <= state_r == S_IDLE && INSTR_VALID_I &&
                   !(w_shift || w_mshift || w_branch || w_bitdyn || w_bitsta);
      DREG_WE_O <= fin && (kind_r == K_SHIFT || kind_r == K_BIT);
      DREG_WSEL_O <= op_r[2:0];
      DREG_WDATA_O <= (kind_r == K_BIT) ? inv_val : alu_bus.result;
      FLAGS_WE_O <= (fin && (kind_r == K_SHIFT || kind_r == K_BIT)) || mem_end;
      FLAGS_O <= (kind_r == K_BIT) ? {FLAGS_I.x, FLAGS_I.n, !tested, FLAGS_I.v, FLAGS_I.c} :
                 alu_bus.flags_out;
      PC_WE_O <= fin && kind_r == K_BRANCH && cond_true;
      PC_O <= pc_r + sbbd_pkg::PC_STEP + disp_r;
      MEM_WDATA_O <= (kind_r == K_BIT) ? inv_val : alu_bus.result;
    end
  end

  // request levels drop on the edge that sees the answer, so no transfer repeats
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      BUSY_O <= 1'b0;
      EXT_REQ_O <= 1'b0;
      DREG_RSEL_O <= 3'h0;
      MEM_RREQ_O <= 1'b0;
      MEM_WREQ_O <= 1'b0;
      MEM_EA_O <= 6'h00;
      MEM_BYTE_O <= 1'b0;
    end else begin
      BUSY_O <= state_r != S_IDLE || INSTR_VALID_I;
      EXT_REQ_O <= state_r inside {S_EXT_HI, S_EXT_LO, S_BIT_NUM} && !EXT_VALID_I;
      DREG_RSEL_O <= (state_r != S_IDLE) ? op_r[2:0] :
                     (w_shift && !INSTR_WORD_I[5]) ? INSTR_WORD_I[2:0] : INSTR_WORD_I[11:9];
      MEM_RREQ_O <= state_r == S_MEM_RD && !MEM_RVALID_I;
      MEM_WREQ_O <= state_r == S_MEM_WR && !MEM_WDONE_I;
      MEM_EA_O <= op_r[5:0];
      MEM_BYTE_O <= kind_r == K_BIT;
    end
  end
endmodule : sbbd_top

// ==== shared/sbbd_pkg.sv ====
// package: encodings, field positions and constants of the shift/branch/bit-invert decoder
// How it works
// - immediate count zero means eight
// - register count taken modulo sixty-four
// - direction zero right, one left
// - size 00 byte, 01 word, 10 long
// - register shift uses low register field
// - memory shift accepts memory alterable modes only
// - taken branch loads address plus two plus displacement
// - displacement is signed byte distance
// - zero short displacement fetches word extension
// - all-ones short displacement fetches long extension
// - four-bit condition field decode
// - bit invert sets zero flag, others kept
// - register modulo 32 long, memory modulo 8 byte
// - bit zero is least significant
// - bit number static word or data register
// - left shift fills zeros, overflow on sign change
// - right shift replicates sign bit
// - zero count keeps extend, clears carry
// - memory shift is word by one
package sbbd_pkg;
  // ****************************************************************
  // opcode fields
  // ****************************************************************
  localparam logic [3:0] OP_SHIFT = 4'he;
  localparam logic [3:0] OP_BRANCH = 4'h6;
  localparam logic [3:0] OP_BITOP = 4'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [1:0] SIZE_MEM = 2'h3;
  localparam logic [1:0] SHIFT_KIND_ARITH = 2'h0;
  localparam logic [2:0] MODE_DREG = 3'h0;
  localparam logic [2:0] MODE_IND_FIRST = 3'h2;
  localparam logic [2:0] MODE_IND_LAST = 3'h6;
  localparam logic [2:0] MODE_EXT = 3'h7;
  localparam logic [2:0] EXT_ABS_W = 3'h0;
  localparam logic [2:0] EXT_ABS_L = 3'h1;
  localparam logic [2:0] BITOP_INVERT = 3'h5;
  localparam logic [7:0] STATIC_BITOP_HI = 8'h08;
  localparam logic [1:0] STATIC_INVERT_TYPE = 2'h1;
  localparam logic [7:0] DISP_WORD = 8'h00;
  localparam logic [7:0] DISP_LONG = 8'hff;
  localparam logic [31:0] PC_STEP = 32'h0000_0002;
  localparam logic [5:0] COUNT_MOD_MASK = 6'h3f;
  localparam logic [3:0] COUNT_ZERO_MEANS = 4'h8;
  // ****************************************************************
  // condition codes
  // ****************************************************************
  typedef enum logic [3:0] {
    CC_T = 4'h0, CC_F = 4'h1, CC_HI = 4'h2, CC_LS = 4'h3,
    CC_CC = 4'h4, CC_CS = 4'h5, CC_NE = 4'h6, CC_EQ = 4'h7,
    CC_VC = 4'h8, CC_VS = 4'h9, CC_PL = 4'ha, CC_MI = 4'hb,
    CC_GE = 4'hc, CC_LT = 4'hd, CC_GT = 4'he, CC_LE = 4'hf
  } sbbd_cond_t;
  typedef struct packed {
    logic x;
    logic n;
    logic z;
    logic v;
    logic c;
  } sbbd_flags_t;
endpackage : sbbd_pkg

// ==== shared/sbbd_alu_if.sv ====
// interface: operand/result bundle between the sequencer and the shifter
`timescale 1ns/100ps
interface sbbd_alu_if;
  logic [31:0] operand;
  logic [6:0] count;
  logic [1:0] size;
  logic left;
  logic [31:0] result;
  sbbd_pkg::sbbd_flags_t flags_in;
  sbbd_pkg::sbbd_flags_t flags_out;
  modport seq (output operand, count, size, left, flags_in, input result, flags_out);
  modport alu (input operand, count, size, left, flags_in, output result, flags_out);
endinterface : sbbd_alu_if

// ==== logic/sbbd_cond.sv ====
// module: branch condition evaluator
`timescale 1ns/100ps
module sbbd_cond (
  input wire logic [3:0] cond_i,
  input wire sbbd_pkg::sbbd_flags_t flags_i,
  output logic true_o
);
  logic n_ne_v;
  assign n_ne_v = flags_i.n ^ flags_i.v;
  always_comb begin
    unique case (sbbd_pkg::sbbd_cond_t'(cond_i))
      sbbd_pkg::CC_T: true_o = 1'b1;
      sbbd_pkg::CC_F: true_o = 1'b0;
      sbbd_pkg::CC_HI: true_o = !flags_i.c && !flags_i.z;
      sbbd_pkg::CC_LS: true_o = flags_i.c || flags_i.z;
      sbbd_pkg::CC_CC: true_o = !flags_i.c;
      sbbd_pkg::CC_CS: true_o = flags_i.c;
      sbbd_pkg::CC_NE: true_o = !flags_i.z;
      sbbd_pkg::CC_EQ: true_o = flags_i.z;
      sbbd_pkg::CC_VC: true_o = !flags_i.v;
      sbbd_pkg::CC_VS: true_o = flags_i.v;
      sbbd_pkg::CC_PL: true_o = !flags_i.n;
      sbbd_pkg::CC_MI: true_o = flags_i.n;
      sbbd_pkg::CC_GE: true_o = !n_ne_v;
      sbbd_pkg::CC_LT: true_o = n_ne_v;
      sbbd_pkg::CC_GT: true_o = !n_ne_v && !flags_i.z;
      sbbd_pkg::CC_LE: true_o = flags_i.z || n_ne_v;
    endcase
  end
endmodule : sbbd_cond

// ==== logic/sbbd_shift.sv ====
// module: arithmetic shifter with flag generation
`timescale 1ns/100ps
module sbbd_shift (
  sbbd_alu_if.alu alu
);
  function automatic logic msb_of(input logic [31:0] v, input logic [1:0] sz);
    unique case (sz)
      sbbd_pkg::SIZE_BYTE: msb_of = v[7];
      sbbd_pkg::SIZE_WORD: msb_of = v[15];
      default: msb_of = v[31];
    endcase
  endfunction : msb_of

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                        input logic [1:0] sz);
    unique case (sz)
      sbbd_pkg::SIZE_BYTE: merge = {old[31:8], nv[7:0]};
      sbbd_pkg::SIZE_WORD: merge = {old[31:16], nv[15:0]};
      default: merge = nv;
    endcase
  endfunction : merge

  // bit-serial loop: at most 63 steps, simple and exact for the overflow rule
  always_comb begin
    logic [31:0] v;
    logic last;
    logic ovf;
    logic s0;
    v = alu.operand;
    last = 1'b0;
    ovf = 1'b0;
    s0 = msb_of(alu.operand, alu.size);
    for (int i = 0; i < 64; i++) begin
      if (7'(i) < alu.count) begin
        if (alu.left) begin
          last = msb_of(v, alu.size);
          v = {v[30:0], 1'b0};
          if (msb_of(v, alu.size) != s0) ovf = 1'b1;
        end else begin
          last = v[0];
          v = {v[31], v[31:1]};
          unique case (alu.size)
            sbbd_pkg::SIZE_BYTE: v[7] = v[6];
            sbbd_pkg::SIZE_WORD: v[15] = v[14];
            default: v[31] = v[30];
          endcase
        end
      end
    end
    alu.result = merge(alu.operand, v, alu.size);
    alu.flags_out.n = msb_of(v, alu.size);
    unique case (alu.size)
      sbbd_pkg::SIZE_BYTE: alu.flags_out.z = (v[7:0] == 8'h00);
      sbbd_pkg::SIZE_WORD: alu.flags_out.z = (v[15:0] == 16'h0000);
      default: alu.flags_out.z = (v == 32'h0000_0000);
    endcase
    alu.flags_out.v = ovf;
    alu.flags_out.c = (alu.count == 7'h00) ? 1'b0 : last;
    alu.flags_out.x = (alu.count == 7'h00) ? alu.flags_in.x : last;
  end
endmodule : sbbd_shift

// ==== dv/sbbd_top_sva.sv ====
// checker: port-level properties of the shift, branch and bit-invert decoder
`timescale 1ns/100ps
module sbbd_top_sva (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic INSTR_VALID_I,
  input wire logic [15:0] INSTR_WORD_I,
  input wire logic [31:0] INSTR_PC_I,
  input wire sbbd_pkg::sbbd_flags_t FLAGS_I,
  input wire logic BUSY_O,
  input wire logic DONE_O,
  input wire logic ILLEGAL_O,
  input wire logic EXT_REQ_O,
  input wire logic DREG_WE_O,
  input wire logic [2:0] DREG_WSEL_O,
  input wire logic MEM_RREQ_O,
  input wire logic MEM_WREQ_O,
  input wire logic MEM_BYTE_O,
  input wire logic FLAGS_WE_O,
  input wire sbbd_pkg::sbbd_flags_t FLAGS_O,
  input wire logic PC_WE_O,
  input wire logic [31:0] PC_O
);
  // ****************************************************************
  // opcode of the instruction in flight
  // ****************************************************************
  logic [15:0] op_r;
  logic [31:0] pc_r;
  logic is_bra, is_msh, is_rsh, is_bit, bad_ea;
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      op_r <= 16'h0000;
      pc_r <= 32'h0000_0000;
    end else if (INSTR_VALID_I && !BUSY_O) begin
      op_r <= INSTR_WORD_I;
      pc_r <= INSTR_PC_I;
    end
  end
  assign is_bra = op_r[15:12] == 4'h6;
  assign is_msh = op_r[15:9] == 7'h70 && op_r[7:6] == 2'h3;
  assign is_rsh = op_r[15:12] == 4'he && op_r[7:6] != 2'h3 && op_r[4:3] == 2'h0;
  assign is_bit = op_r[15:12] == 4'h0 && op_r[7:6] == 2'h1 && (op_r[8] || op_r[11:8] == 4'h8);
  assign bad_ea = op_r[5:4] == 2'h0 || (op_r[5:3] == 3'h7 && op_r[2:1] != 2'h0);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // ****************************************************************
  // properties
  // ****************************************************************
  a_illegal_ends: assert property (ILLEGAL_O |=> DONE_O)
    else $error("illegal flag without done");
  a_mshift_bad_ea: assert property (DONE_O && is_msh && bad_ea |-> $past(ILLEGAL_O))
    else $error("memory shift accepted a non-alterable operand");
  a_mshift_word: assert property (MEM_RREQ_O && is_msh |-> !MEM_BYTE_O)
    else $error("memory shift not word sized");
  a_bit_mem_byte: assert property ((MEM_RREQ_O || MEM_WREQ_O) && is_bit |-> MEM_BYTE_O)
    else $error("memory bit invert not byte sized");
  a_branch_no_flags: assert property (FLAGS_WE_O |-> !is_bra)
    else $error("branch wrote flags");
  a_pc_only_branch: assert property (PC_WE_O |-> is_bra)
    else $error("program counter written outside a branch");
  a_short_disp_pc: assert property (PC_WE_O && op_r[7:0] != 8'h00 && op_r[7:0] != 8'hff
    |-> PC_O == pc_r + 32'h2 + {{24{op_r[7]}}, op_r[7:0]})
    else $error("short branch target wrong");
  a_ext_long_short: assert property (EXT_REQ_O && is_bra
    |-> op_r[7:0] == 8'h00 || op_r[7:0] == 8'hff)
    else $error("extension fetched for a short branch");
  a_rshift_dest: assert property (DREG_WE_O && is_rsh |-> DREG_WSEL_O == op_r[2:0])
    else $error("shift result to wrong register");
  a_bit_flags_kept: assert property (FLAGS_WE_O && is_bit |-> FLAGS_O.x == FLAGS_I.x
    && FLAGS_O.n == FLAGS_I.n && FLAGS_O.v == FLAGS_I.v && FLAGS_O.c == FLAGS_I.c)
    else $error("bit invert changed a flag other than zero");
endmodule : sbbd_top_sva

bind sbbd_top sbbd_top_sva chk_u (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .INSTR_VALID_I(INSTR_VALID_I),
  .INSTR_WORD_I(INSTR_WORD_I), .INSTR_PC_I(INSTR_PC_I), .FLAGS_I(FLAGS_I),
  .BUSY_O(BUSY_O), .DONE_O(DONE_O), .ILLEGAL_O(ILLEGAL_O), .EXT_REQ_O(EXT_REQ_O),
  .DREG_WE_O(DREG_WE_O), .DREG_WSEL_O(DREG_WSEL_O), .MEM_RREQ_O(MEM_RREQ_O),
  .MEM_WREQ_O(MEM_WREQ_O), .MEM_BYTE_O(MEM_BYTE_O), .FLAGS_WE_O(FLAGS_WE_O),
  .FLAGS_O(FLAGS_O), .PC_WE_O(PC_WE_O), .PC_O(PC_O)
);

// ==== dv/sbbd_partner.sv ====
// partner: fetch stream, data register file and operand memory beside the decoder
`timescale 1ns/100ps
module sbbd_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_req_i,
  input wire logic [2:0] rsel_i,
  input wire logic rreq_i,
  input wire logic wreq_i,
  output logic ext_valid_o,
  output logic [15:0] ext_word_o,
  output logic [31:0] dreg_o,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic wdone_o
);
  logic [31:0] dreg [8];
  logic [15:0] ext_q [$];
  logic [31:0] mem_word;
  int ext_wt, rd_wt, wr_wt;
  assign dreg_o = dreg[rsel_i];
  initial begin
    {ext_valid_o, rvalid_o, wdone_o} = 3'h0;
    ext_word_o = 16'h0000;
    rdata_o = 32'h0000_0000;
  end
  // idle data lines toggle so a stale word is never mistaken for a fresh one
  always @(posedge clk_i) begin
    if (rst_i || ext_valid_o || !ext_req_i || ext_q.size() == 0) begin
      ext_valid_o <= 1'b0;
      ext_word_o <= ~ext_word_o;
    end else if (ext_wt > 0) begin
      ext_wt <= ext_wt - 1;
      ext_word_o <= ~ext_word_o;
    end else begin
      ext_valid_o <= 1'b1;
      ext_word_o <= ext_q.pop_front();
      ext_wt <= $urandom_range(3);
    end
  end
  always @(posedge clk_i) begin
    if (rst_i || rvalid_o || !rreq_i || rd_wt > 0) begin
      rvalid_o <= 1'b0;
      rdata_o <= ~rdata_o;
      rd_wt <= (rd_wt > 0 && rreq_i) ? rd_wt - 1 : rd_wt;
    end else begin
      rvalid_o <= 1'b1;
      rdata_o <= mem_word;
      rd_wt <= $urandom_range(3);
    end
  end
  always @(posedge clk_i) begin
    if (rst_i || wdone_o || !wreq_i || wr_wt > 0) begin
      wdone_o <= 1'b0;
      wr_wt <= (wr_wt > 0 && wreq_i) ? wr_wt - 1 : wr_wt;
    end else begin
      wdone_o <= 1'b1;
      wr_wt <= $urandom_range(3);
    end
  end
endmodule : sbbd_partner

// ==== dv/sbbd_tb.sv ====
// testbench: reference-model bench for the shift, branch and bit-invert decoder
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0, rst = 1'b1, ivalid = 1'b0;
  logic [15:0] iword = 16'h0000, ext_word;
  logic [31:0] ipc = 32'h0, dreg_in, rdata, wdata, mwdata, pc_out;
  logic ext_valid, rvalid, wdone, busy, done, ill, ext_req, dwe, fwe, pwe, rreq, wreq, mbyte;
  logic [2:0] rsel, wsel;
  logic [5:0] mea;
  sbbd_pkg::sbbd_flags_t flags_in = 5'h00, flags_out;
  int error_cnt = 0, checked = 0, n_dwe, n_fwe, n_pwe, n_mw, n_ill;
  logic [31:0] c_dw, c_pc, c_mw;
  logic [4:0] c_fl;
  logic [2:0] c_ws;
  logic [5:0] c_ea;
  logic c_byte;
  always #5 clk = ~clk;
  sbbd_top dut_u (.CLK_I(clk), .RESET_I(rst), .INSTR_VALID_I(ivalid), .INSTR_WORD_I(iword),
    .INSTR_PC_I(ipc), .EXT_VALID_I(ext_valid), .EXT_WORD_I(ext_word), .DREG_FILE_I(dreg_in),
    .MEM_RDATA_I(rdata), .MEM_RVALID_I(rvalid), .MEM_WDONE_I(wdone), .FLAGS_I(flags_in),
    .BUSY_O(busy), .DONE_O(done), .ILLEGAL_O(ill), .EXT_REQ_O(ext_req), .DREG_RSEL_O(rsel),
    .DREG_WE_O(dwe), .DREG_WSEL_O(wsel), .DREG_WDATA_O(wdata), .MEM_RREQ_O(rreq),
    .MEM_WREQ_O(wreq), .MEM_EA_O(mea), .MEM_BYTE_O(mbyte), .MEM_WDATA_O(mwdata),
    .FLAGS_WE_O(fwe), .FLAGS_O(flags_out), .PC_WE_O(pwe), .PC_O(pc_out));
  sbbd_partner partner_u (.clk_i(clk), .rst_i(rst), .ext_req_i(ext_req), .rsel_i(rsel),
    .rreq_i(rreq), .wreq_i(wreq), .ext_valid_o(ext_valid), .ext_word_o(ext_word),
    .dreg_o(dreg_in), .rdata_o(rdata), .rvalid_o(rvalid), .wdone_o(wdone));
  // ****************************************************************
  // reference models
  // ****************************************************************
  function automatic logic [36:0] shift_ref(input logic [31:0] v, input int k, input int w,
                                            input logic lf, input logic [4:0] f);
    logic [31:0] m, r;
    logic c, ov;
    m = (w == 32) ? 32'hffff_ffff : ((32'h1 << w) - 32'h1);
    r = v & m;
    c = 1'b0;
    ov = 1'b0;
    for (int i = 0; i < k; i++) begin
      c = lf ? r[w - 1] : r[0];
      r = lf ? ((r << 1) & m) : ((r >> 1) | (32'(r[w - 1]) << (w - 1)));
      if (lf && r[w - 1] != c) ov = 1'b1;
    end
    return {(k == 0) ? f[4] : c, r[w - 1], r == 32'h0, ov, c, (v & ~m) | r};
  endfunction : shift_ref
  function automatic logic cond_ref(input logic [3:0] cc, input logic [4:0] f);
    logic [15:0] t;
    t = {f[2] | (f[3] ^ f[1]), !f[2] & !(f[3] ^ f[1]), f[3] ^ f[1], !(f[3] ^ f[1]), f[3],
         !f[3], f[1], !f[1], f[2], !f[2], f[0], !f[0], f[0] | f[2], !f[0] & !f[2], 2'h1};
    return t[cc];
  endfunction : cond_ref
  // ****************************************************************
  // drivers and checks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // a second valid while busy must be ignored, so odd-numbered shift tests hold valid one extra edge
  task automatic run(input logic [15:0] op, input logic [31:0] pc, input logic [4:0] fl,
                     input bit poke);
    {n_dwe, n_fwe, n_pwe, n_mw, n_ill} = '0;
    for (int i = 0; i < 20 && busy !== 1'b0; i++) @(posedge clk);
    @(posedge clk);
    ivalid <= 1'b1;
    iword <= op;
    ipc <= pc;
    flags_in <= fl;
    @(posedge clk);
    ivalid <= poke;
    iword <= ~op;
    for (int i = 0; i < 200; i++) begin
      #1;
      if (dwe === 1'b1) {n_dwe, c_dw, c_ws} = {n_dwe + 1, wdata, wsel};
      if (fwe === 1'b1) {n_fwe, c_fl} = {n_fwe + 1, flags_out};
      if (pwe === 1'b1) {n_pwe, c_pc} = {n_pwe + 1, pc_out};
      if (wreq === 1'b1 && n_mw == 0) {n_mw, c_mw, c_byte, c_ea} = {32'd1, mwdata, mbyte, mea};
      if (ill === 1'b1) n_ill++;
      if (done === 1'b1) break;
      @(posedge clk);
      ivalid <= 1'b0;
    end
    chk("done", 1, done);
    partner_u.ext_q.delete();
  endtask : run
  task automatic summarize;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    #200_000;
    error_cnt++;
    summarize();
  end
  initial begin
    logic [36:0] ex;
    logic [31:0] pc, dw, mw;
    logic [7:0] d8, bn;
    logic [4:0] fl;
    logic [3:0] cc;
    logic [2:0] cf, rg, md;
    logic [1:0] sz;
    logic ir, dr, tk, z, bad;
    int k;
    void'($urandom(34510));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int t = 0; t < 144; t++) begin
      {fl, sz, cf, rg, md, ir, dr, bn, mw, dw} = {$urandom, $urandom, $urandom};
      for (int i = 0; i < 8; i++) partner_u.dreg[i] = $urandom;
      partner_u.mem_word = mw;
      pc = $urandom & 32'hffff_fffe;
      if (t < 60) begin
        sz = (sz == 2'h3) ? 2'h2 : sz;
        ir = (t < 3) ? 1'b1 : ir;
        if (t < 3) partner_u.dreg[cf] = 32'h40 * t;
        k = ir ? int'(partner_u.dreg[cf][5:0]) : ((cf == 3'h0) ? 8 : int'(cf));
        ex = shift_ref(partner_u.dreg[rg], k, 8 << sz, dr, fl);
        run({4'he, cf, dr, sz, ir, 2'h0, rg}, pc, fl, t[0]);
        chk("dreg sel", rg, c_ws);
        chk("shift data", ex[31:0], c_dw);
        chk("shift flags", ex[36:32], c_fl);
      end else if (t < 108) begin
        cc = 4'(t % 16);
        d8 = 8'($urandom_range(254, 1));
        if (t < 76) dw = {{24{d8[7]}}, d8};
        if (t >= 76) d8 = (t < 92) ? 8'h00 : 8'hff;
        if (t >= 76 && t < 92) dw = (cc == 4'h0) ? 32'h0 : {{16{dw[15]}}, dw[15:0]};
        if (t >= 92) partner_u.ext_q.push_back(dw[31:16]);
        if (t >= 76) partner_u.ext_q.push_back(dw[15:0]);
        tk = cond_ref(cc, fl);
        run({4'h6, cc, d8}, pc, fl, 1'b0);
        chk("branch taken", tk, n_pwe);
        if (tk) chk("branch target", pc + 32'h2 + dw, c_pc);
        chk("branch flags", 0, n_fwe);
      end else if (t < 132) begin
        md = t[1] ? 3'h2 : 3'h0;
        if (!t[0]) partner_u.ext_q.push_back({8'h00, bn});
        if (t[0]) bn = partner_u.dreg[cf][7:0];
        run(t[0] ? {4'h0, cf, 3'h5, md, rg} : {8'h08, 2'h1, md, rg}, pc, fl, 1'b0);
        z = t[1] ? !mw[bn[2:0]] : !partner_u.dreg[rg][bn[4:0]];
        if (t[1]) chk("bit mem", mw[7:0] ^ (8'h1 << bn[2:0]), c_mw[7:0]);
        if (t[1]) chk("bit byte", 1, c_byte);
        if (!t[1]) chk("bit reg", partner_u.dreg[rg] ^ (32'h1 << bn[4:0]), c_dw);
        chk("bit flags", {fl[4:3], z, fl[1:0]}, c_fl);
      end else begin
        md = (t < 140) ? 3'(t - 132) : 3'h7;
        rg = (t < 140) ? rg : 3'(t - 140);
        bad = md < 3'h2 || (md == 3'h7 && rg > 3'h1);
        ex = shift_ref(mw, 1, 16, dr, fl);
        run({7'h70, dr, 2'h3, md, rg}, pc, fl, 1'b0);
        chk("mem shift refused", bad, n_ill);
        if (bad) chk("refused writes", 0, n_dwe + n_fwe + n_pwe);
        if (!bad) chk("mem shift data", ex[15:0], c_mw[15:0]);
        if (!bad) chk("mem shift flags", ex[36:32], c_fl);
        if (!bad) chk("mem shift ea", {md, rg}, c_ea);
      end
    end
    run(16'hffff, 32'h100, 5'h00, 1'b0);
    chk("unknown opcode", 1, n_ill);
    summarize();
  end
endmodule : testbench
